// ### sso_top.v
`timescale 1ns/10ps
`include "sso_map.vh"

module sso_top #(
   parameter SPD_W = 16,
   parameter POS_W = 32,
   parameter NUM_DO = 6
) (
   input wire clk_i,                        // 100 MHz control clock
   input wire rst_i,                        // Synchronous reset, active high
   input wire ce_i,                         // Clock enable, freezes all state
   input wire [5:0] avs_address_i,          // Avalon word address
   input wire avs_read_i,                   // Avalon read
   input wire avs_write_i,                  // Avalon write
   input wire [31:0] avs_writedata_i,       // Avalon write data
   input wire [3:0] avs_byteenable_i,       // Avalon byte enables
   output wire [31:0] avs_readdata_o,       // Avalon read data
   output wire avs_waitrequest_o,           // Avalon wait request
   input wire power_good_i,                 // Supply present, pin
   input wire servo_on_i,                   // Servo-on digital input, pin
   input wire ctrl_alarm_i,                 // Control circuit alarm
   input wire pwr_alarm_i,                  // Motor power circuit alarm
   input wire other_alarm_i,                // Any other alarm
   input wire fwd_limit_i,                  // Forward limit
   input wire rev_limit_i,                  // Reverse limit
   input wire estop_i,                      // Emergency stop
   input wire comm_err_i,                   // Communication error
   input wire undervolt_i,                  // Undervoltage
   input wire servo_ok_i,                   // Servo circuit operating normally
   input wire torque_limiting_i,            // Torque limiter active
   input wire overload_reached_i,           // Overload level reached
   input wire brake_release_i,              // Brake release request
   input wire signed [SPD_W-1:0] fb_speed_i,   // Feedback speed, r/min
   input wire signed [SPD_W-1:0] cmd_speed_i,  // Commanded speed, r/min
   input wire signed [POS_W-1:0] pos_err_i,    // Position deviation, pulses
   output reg drive_ready_out_o,            // Ready flag
   output reg servo_enable_out_o,           // Servo enabled flag
   output reg near_zero_velocity_out_o,     // Near zero speed flag
   output reg above_speed_out_o,            // Above speed flag
   output reg in_position_out_o,            // In position flag
   output reg torque_limit_active_out_o,    // Torque limiting flag
   output reg fault_flag_out_o,             // Fault flag
   output reg brake_control_out_o,          // Brake contact control
   output reg overload_level_out_o,         // Overload level flag
   output reg caution_out_o,                // Caution flag
   output reg velocity_match_out_o,         // Speed match flag
   output reg [NUM_DO-1:0] do_o,            // Output terminals
   output wire irq_o                        // Level interrupt
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   reg [1:0] pg_sync_ff;
   reg [1:0] son_sync_ff;

   // Two stages; only the second stage feeds logic
   always @(posedge clk_i) begin
      if (rst_i) begin
         pg_sync_ff <= 2'h0;
         son_sync_ff <= 2'h0;
      end else if (ce_i) begin
         pg_sync_ff <= {pg_sync_ff[0], power_good_i};
         son_sync_ff <= {son_sync_ff[0], servo_on_i};
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   reg [2:0] mode_ff;
   reg [SPD_W-1:0] near_zero_velocity_out_ff;
   reg [SPD_W-1:0] above_speed_out_ff;
   reg [POS_W-1:0] pwin_ff;
   reg [SPD_W-1:0] swin_ff;
   reg [4*NUM_DO-1:0] dmap_ff;
   reg [2:0] ista_ff;
   reg [2:0] imsk_ff;
   reg ack_ff;
   reg [31:0] rdata_ff;
   reg [2:0] evt_prev_ff;

   wire [7:0] byte_addr;
   wire req;
   wire wr_go;
   wire [31:0] wmask;
   wire [31:0] wdat;

   assign byte_addr = {avs_address_i, 2'b00};
   assign req = avs_read_i | avs_write_i;
   // One wait cycle per access so read data come from a flop
   assign avs_waitrequest_o = req & ~ack_ff;
   assign wr_go = avs_write_i & ~ack_ff & ce_i;
   assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   assign avs_readdata_o = rdata_ff;

   // ****************************************
   // Comparisons and flags
   // ****************************************
   function [POS_W-1:0] mag;
      input [POS_W-1:0] v;
      begin
         mag = v[POS_W-1] ? (~v + 1'b1) : v;
      end
   endfunction

   wire [POS_W-1:0] spd_mag;
   wire [POS_W-1:0] sdiff_mag;
   wire [POS_W-1:0] perr_mag;
   wire signed [SPD_W:0] sdiff;
   wire caution_cond;
   wire pos_mode;
   wire trq_mode;
   wire spd_mode;
   reg [`SSO_NUM_FN-1:0] fn;
   wire [NUM_DO-1:0] do_nxt;
   wire [2:0] evt;

   // Sign extension keeps one magnitude function for all widths
   assign spd_mag = mag({{(POS_W-SPD_W){fb_speed_i[SPD_W-1]}}, fb_speed_i});
   assign sdiff = {cmd_speed_i[SPD_W-1], cmd_speed_i} - {fb_speed_i[SPD_W-1], fb_speed_i};
   assign sdiff_mag = mag({{(POS_W-SPD_W-1){sdiff[SPD_W]}}, sdiff});
   assign perr_mag = mag(pos_err_i);
   assign caution_cond = fwd_limit_i | rev_limit_i | estop_i | comm_err_i | undervolt_i;
   assign pos_mode = (mode_ff == `SSO_MODE_PT) || (mode_ff == `SSO_MODE_PT_S) ||
                     (mode_ff == `SSO_MODE_PT_T);
   assign trq_mode = (mode_ff == `SSO_MODE_T) || (mode_ff == `SSO_MODE_TZ);
   assign spd_mode = (mode_ff == `SSO_MODE_S) || (mode_ff == `SSO_MODE_SZ);

   // Fresh flag set from current inputs each cycle
   always @* begin
      fn = {`SSO_NUM_FN{1'b0}};
      fn[`SSO_FN_READY] = pg_sync_ff[1] & ~ctrl_alarm_i & ~pwr_alarm_i;
      fn[`SSO_FN_SERVO] = son_sync_ff[1] & servo_ok_i;
      fn[`SSO_FN_ZERO] = spd_mag < {{(POS_W-SPD_W){1'b0}}, near_zero_velocity_out_ff};
      fn[`SSO_FN_ABOVE] = spd_mag > {{(POS_W-SPD_W){1'b0}}, above_speed_out_ff};
      fn[`SSO_FN_INPOS] = pos_mode & (perr_mag < pwin_ff);
      fn[`SSO_FN_TQL] = ~trq_mode & torque_limiting_i;
      fn[`SSO_FN_FAULT] = ctrl_alarm_i | pwr_alarm_i | other_alarm_i;
      fn[`SSO_FN_BRAKE] = brake_release_i & son_sync_ff[1] & servo_ok_i;
      fn[`SSO_FN_OLW] = overload_reached_i;
      fn[`SSO_FN_WARN] = caution_cond;
      fn[`SSO_FN_VMATCH] = spd_mode &
                           (sdiff_mag < {{(POS_W-SPD_W){1'b0}}, swin_ff});
   end

   sso_dout_map #(
      .NUM_DO(NUM_DO)
   ) u_map (
      .func_i(fn),
      .map_i(dmap_ff),
      .mode_i(mode_ff),
      .do_o(do_nxt)
   );

   // Flags registered every enabled cycle, no holdover
   always @(posedge clk_i) begin
      if (rst_i) begin
         drive_ready_out_o <= 1'b0;
         servo_enable_out_o <= 1'b0;
         near_zero_velocity_out_o <= 1'b0;
         above_speed_out_o <= 1'b0;
         in_position_out_o <= 1'b0;
         torque_limit_active_out_o <= 1'b0;
         fault_flag_out_o <= 1'b0;
         brake_control_out_o <= 1'b0;
         overload_level_out_o <= 1'b0;
         caution_out_o <= 1'b0;
         velocity_match_out_o <= 1'b0;
         do_o <= {NUM_DO{1'b0}};
      end else if (ce_i) begin
         drive_ready_out_o <= fn[`SSO_FN_READY];
         servo_enable_out_o <= fn[`SSO_FN_SERVO];
         near_zero_velocity_out_o <= fn[`SSO_FN_ZERO];
         above_speed_out_o <= fn[`SSO_FN_ABOVE];
         in_position_out_o <= fn[`SSO_FN_INPOS];
         torque_limit_active_out_o <= fn[`SSO_FN_TQL];
         fault_flag_out_o <= fn[`SSO_FN_FAULT];
         brake_control_out_o <= fn[`SSO_FN_BRAKE];
         overload_level_out_o <= fn[`SSO_FN_OLW];
         caution_out_o <= fn[`SSO_FN_WARN];
         velocity_match_out_o <= fn[`SSO_FN_VMATCH];
         do_o <= do_nxt;
      end
   end

   // ****************************************
   // Interrupt events
   // ****************************************
   assign evt = {fn[`SSO_FN_OLW], fn[`SSO_FN_WARN], fn[`SSO_FN_FAULT]};
   assign irq_o = |(ista_ff & imsk_ff);

   // Rising edges set sticky bits; set beats a same-cycle clear
   always @(posedge clk_i) begin
      if (rst_i) begin
         evt_prev_ff <= 3'h0;
         ista_ff <= 3'h0;
      end else if (ce_i) begin
         evt_prev_ff <= evt;
         if (wr_go && byte_addr == `SSO_REG_ISTA && avs_byteenable_i[0])
            ista_ff <= (ista_ff & ~avs_writedata_i[2:0]) | (evt & ~evt_prev_ff);
         else
            ista_ff <= ista_ff | (evt & ~evt_prev_ff);
      end
   end

   // ****************************************
   // Avalon slave
   // ****************************************
   // Writes land at the first sampling edge, answer one cycle later
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         mode_ff <= `SSO_RST_MODE;
         near_zero_velocity_out_ff <= `SSO_RST_NEAR_ZERO_VELOCITY_OUT;
         above_speed_out_ff <= `SSO_RST_ABOVE_SPEED_OUT;
         pwin_ff <= `SSO_RST_PWIN;
         swin_ff <= `SSO_RST_SWIN;
         dmap_ff <= `SSO_RST_DMAP;
         imsk_ff <= `SSO_RST_IMSK;
      end else if (ce_i) begin
         ack_ff <= req & ~ack_ff;
         if (wr_go) begin
            case (byte_addr)
               `SSO_REG_CTRL: if (avs_byteenable_i[0]) mode_ff <= avs_writedata_i[2:0];
               `SSO_REG_NEAR_ZERO_VELOCITY_OUT: near_zero_velocity_out_ff <= (near_zero_velocity_out_ff & ~wmask[SPD_W-1:0]) |
                                         (avs_writedata_i[SPD_W-1:0] & wmask[SPD_W-1:0]);
               `SSO_REG_ABOVE_SPEED_OUT: above_speed_out_ff <= (above_speed_out_ff & ~wmask[SPD_W-1:0]) |
                                         (avs_writedata_i[SPD_W-1:0] & wmask[SPD_W-1:0]);
               `SSO_REG_PWIN: pwin_ff <= (pwin_ff & ~wmask[POS_W-1:0]) |
                                         (avs_writedata_i[POS_W-1:0] & wmask[POS_W-1:0]);
               `SSO_REG_SWIN: swin_ff <= (swin_ff & ~wmask[SPD_W-1:0]) |
                                         (avs_writedata_i[SPD_W-1:0] & wmask[SPD_W-1:0]);
               `SSO_REG_DMAP: dmap_ff <= (dmap_ff & ~wmask[4*NUM_DO-1:0]) |
                                 (avs_writedata_i[4*NUM_DO-1:0] & wmask[4*NUM_DO-1:0]);
               `SSO_REG_IMSK: if (avs_byteenable_i[0]) imsk_ff <= avs_writedata_i[2:0];
               default: mode_ff <= mode_ff;
            endcase
         end
         // Unmapped reads answer zero
         if (avs_read_i && !ack_ff) begin
            rdata_ff <= 32'h00000000;
            case (byte_addr)
               `SSO_REG_CTRL: rdata_ff[2:0] <= mode_ff;
               `SSO_REG_NEAR_ZERO_VELOCITY_OUT: rdata_ff[SPD_W-1:0] <= near_zero_velocity_out_ff;
               `SSO_REG_ABOVE_SPEED_OUT: rdata_ff[SPD_W-1:0] <= above_speed_out_ff;
               `SSO_REG_PWIN: rdata_ff[POS_W-1:0] <= pwin_ff;
               `SSO_REG_SWIN: rdata_ff[SPD_W-1:0] <= swin_ff;
               `SSO_REG_DMAP: rdata_ff[4*NUM_DO-1:0] <= dmap_ff;
               `SSO_REG_FLAG: rdata_ff[`SSO_NUM_FN-1:0] <= fn;
               `SSO_REG_ISTA: rdata_ff[2:0] <= ista_ff;
               `SSO_REG_IMSK: rdata_ff[2:0] <= imsk_ff;
               `SSO_REG_DOUT: rdata_ff[NUM_DO-1:0] <= do_o;
               default: rdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

// ### sso_map.vh
`ifndef SSO_MAP_VH
`define SSO_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define SSO_REG_CTRL 8'h00
`define SSO_REG_NEAR_ZERO_VELOCITY_OUT 8'h04
`define SSO_REG_ABOVE_SPEED_OUT 8'h08
`define SSO_REG_PWIN 8'h0C
`define SSO_REG_SWIN 8'h10
`define SSO_REG_DMAP 8'h14
`define SSO_REG_FLAG 8'h18
`define SSO_REG_ISTA 8'h1C
`define SSO_REG_IMSK 8'h20
`define SSO_REG_DOUT 8'h24

// ****************************************
// Reset values
// ****************************************
`define SSO_RST_MODE 3'h0
`define SSO_RST_NEAR_ZERO_VELOCITY_OUT 16'h000A
`define SSO_RST_ABOVE_SPEED_OUT 16'h0BB8
`define SSO_RST_PWIN 32'h00000064
`define SSO_RST_SWIN 16'h000A
`define SSO_RST_DMAP 24'h000000
`define SSO_RST_IMSK 3'h0

// ****************************************
// Operating modes
// ****************************************
`define SSO_MODE_PT 3'h0
`define SSO_MODE_S 3'h1
`define SSO_MODE_T 3'h2
`define SSO_MODE_SZ 3'h3
`define SSO_MODE_TZ 3'h4
`define SSO_MODE_PT_S 3'h5
`define SSO_MODE_PT_T 3'h6
`define SSO_MODE_S_T 3'h7

// ****************************************
// Output function codes, 0 = mode default
// ****************************************
`define SSO_FN_DEF 4'h0
`define SSO_FN_READY 4'h1
`define SSO_FN_SERVO 4'h2
`define SSO_FN_ZERO 4'h3
`define SSO_FN_ABOVE 4'h4
`define SSO_FN_INPOS 4'h5
`define SSO_FN_TQL 4'h6
`define SSO_FN_FAULT 4'h7
`define SSO_FN_BRAKE 4'h8
`define SSO_FN_OLW 4'h9
`define SSO_FN_WARN 4'hA
`define SSO_FN_VMATCH 4'hB
`define SSO_FN_NONE 4'hF

// ****************************************
// Field layout
// ****************************************
`define SSO_NUM_FN 12
`define SSO_NUM_DO 6
`define SSO_IRQ_FAULT 0
`define SSO_IRQ_WARN 1
`define SSO_IRQ_OLW 2

`endif

// ### sso_dout_map.v
`timescale 1ns/10ps
`include "sso_map.vh"

// ****************************************
// Terminal function routing
// ****************************************
module sso_dout_map #(
   parameter NUM_DO = 6
) (
   input wire [`SSO_NUM_FN-1:0] func_i,   // Function flags by code
   input wire [4*NUM_DO-1:0] map_i,       // Per-terminal function codes
   input wire [2:0] mode_i,               // Operating mode
   output wire [NUM_DO-1:0] do_o          // Terminal levels
);

   // Factory assignment per terminal, shifts with the mode
   function [3:0] dflt_fn;
      input integer term;
      input [2:0] mode;
      reg pos_mode;
      begin
         pos_mode = (mode == `SSO_MODE_PT) || (mode == `SSO_MODE_PT_S) ||
                    (mode == `SSO_MODE_PT_T);
         case (term)
            0: dflt_fn = `SSO_FN_READY;
            1: dflt_fn = `SSO_FN_ZERO;
            2: dflt_fn = pos_mode ? `SSO_FN_NONE : `SSO_FN_ABOVE;
            3: dflt_fn = pos_mode ? `SSO_FN_INPOS : `SSO_FN_NONE;
            4: dflt_fn = `SSO_FN_FAULT;
            default: dflt_fn = `SSO_FN_NONE;
         endcase
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < NUM_DO; g = g + 1) begin : g_term
         wire [3:0] sel;
         wire [3:0] eff;
         assign sel = map_i[4*g+3:4*g];
         // Zero keeps the default, anything else overrides it
         assign eff = (sel == `SSO_FN_DEF) ? dflt_fn(g, mode_i) : sel;
         // Codes beyond the function set drive the terminal off
         assign do_o[g] = (eff < `SSO_NUM_FN) ? func_i[eff] : 1'b0;
      end
   endgenerate

endmodule

// ### sso_props.sv
`timescale 1ns/10ps
// ****************************************
// Port-level checker
// ****************************************
module sso_props (
   input wire clk_i,                    // Control clock
   input wire rst_i,                    // Synchronous reset
   input wire avs_read_i,               // Bus read
   input wire avs_write_i,              // Bus write
   input wire [31:0] avs_readdata_o,    // Bus read data
   input wire avs_waitrequest_o,        // Bus wait
   input wire power_good_i,             // Supply pin
   input wire servo_on_i,               // Servo-on pin
   input wire ctrl_alarm_i,             // Control alarm
   input wire pwr_alarm_i,              // Power alarm
   input wire other_alarm_i,            // Other alarm
   input wire fwd_limit_i,              // Forward limit
   input wire rev_limit_i,              // Reverse limit
   input wire estop_i,                  // Emergency stop
   input wire comm_err_i,               // Comm error
   input wire undervolt_i,              // Undervoltage
   input wire servo_ok_i,               // Servo healthy
   input wire torque_limiting_i,        // Limiter active
   input wire overload_reached_i,       // Overload reached
   input wire brake_release_i,          // Brake request
   input wire drive_ready_out_o,        // Ready flag
   input wire servo_enable_out_o,       // Servo flag
   input wire torque_limit_active_out_o, // Torque limit flag
   input wire fault_flag_out_o,         // Fault flag
   input wire brake_control_out_o,      // Brake flag
   input wire overload_level_out_o,     // Overload flag
   input wire caution_out_o             // Caution flag
);
   reg [2:0] cnt_ff;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Cycles since reset; pin paths need three clean cycles of history
   always @(posedge clk_i) begin
      if (rst_i) cnt_ff <= 3'h0;
      else if (cnt_ff != 3'h7) cnt_ff <= cnt_ff + 3'h1;
   end
   fault_cause_a: assert property (cnt_ff == 3'h7 |-> fault_flag_out_o ==
      $past(ctrl_alarm_i | pwr_alarm_i | other_alarm_i)) else $error("fault flag wrong");
   caution_cause_a: assert property (cnt_ff == 3'h7 |-> caution_out_o == $past(fwd_limit_i
      | rev_limit_i | estop_i | comm_err_i | undervolt_i)) else $error("caution flag wrong");
   overload_follow_a: assert property (cnt_ff == 3'h7 |->
      overload_level_out_o == $past(overload_reached_i)) else $error("overload flag wrong");
   ready_cause_a: assert property (cnt_ff == 3'h7 |-> drive_ready_out_o == ($past(power_good_i,
      3) & !$past(ctrl_alarm_i) & !$past(pwr_alarm_i))) else $error("ready flag wrong");
   servo_cause_a: assert property (cnt_ff == 3'h7 |-> servo_enable_out_o ==
      ($past(servo_on_i, 3) & $past(servo_ok_i))) else $error("servo flag wrong");
   brake_cause_a: assert property (cnt_ff == 3'h7 |-> brake_control_out_o ==
      ($past(brake_release_i) & $past(servo_on_i, 3) & $past(servo_ok_i)))
      else $error("brake flag wrong");
   torque_cause_a: assert property (cnt_ff == 3'h7 && torque_limit_active_out_o |->
      $past(torque_limiting_i)) else $error("torque flag without limiter");
   bus_wait_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1
      !avs_waitrequest_o) else $error("bus wait state wrong");
   rdata_hold_a: assert property (cnt_ff == 3'h7 && !$past(avs_read_i) |->
      $stable(avs_readdata_o)) else $error("read data moved");
endmodule
bind sso_top sso_props u_props (.*);

// ### sso_plc_model.sv
`timescale 1ns/10ps
// ****************************************
// Controller reading the terminals
// ****************************************
module sso_plc_model (
   input wire clk_i,            // Control clock
   input wire [5:0] do_i,       // Drive terminals
   output reg [5:0] seen_o      // Last levels latched
);
   // Latch each cycle, as an input card scanning the terminals would
   initial seen_o = 6'h00;
   always @(posedge clk_i) begin
      seen_o <= do_i;
   end
endmodule

// ### tb_servo_status_output_logic.sv
`timescale 1ns/10ps
`include "sso_map.vh"
module tb_servo_status_output_logic;
   logic clk_i = 0, rst_i = 1, rd = 0, wr = 0;
   logic [5:0] adr = 6'h00;
   logic [31:0] wd = 32'h0, rdat, rdo;
   logic pg = 0, servo_enable_out = 0, ca = 0, pa = 0, oa = 0, sok = 0, tl = 0, ovl = 0, brk = 0;
   logic [4:0] cv = 5'h00;
   logic signed [15:0] fb = 16'sh0, cmd = 16'sh0;
   logic signed [31:0] pe = 32'sh0;
   wire wq, irq, rdy, sen, nz, ab, ip, tq, flt, bc, ol, cau, vm;
   wire [5:0] dout, seen;
   int fails = 0, checks_done = 0, i;
   logic signed [15:0] sp[6] = '{16'sd9, 16'sd10, -16'sd9, 16'sd3000, 16'sd3001, -16'sd3001};
   logic [1:0] ex[6] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h1, 2'h1};
   logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h3C};
   logic [31:0] rv[8] = '{32'h0, 32'h000A, 32'h0BB8, 32'h64, 32'h000A, 32'h0, 32'h0, 32'h0};
   initial forever #5 clk_i = ~clk_i;
   sso_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdo), .avs_waitrequest_o(wq), .power_good_i(pg), .servo_on_i(servo_enable_out),
      .ctrl_alarm_i(ca), .pwr_alarm_i(pa), .other_alarm_i(oa), .fwd_limit_i(cv[0]),
      .rev_limit_i(cv[1]), .estop_i(cv[2]), .comm_err_i(cv[3]), .undervolt_i(cv[4]),
      .servo_ok_i(sok), .torque_limiting_i(tl), .overload_reached_i(ovl),
      .brake_release_i(brk), .fb_speed_i(fb), .cmd_speed_i(cmd), .pos_err_i(pe),
      .drive_ready_out_o(rdy), .servo_enable_out_o(sen), .near_zero_velocity_out_o(nz),
      .above_speed_out_o(ab), .in_position_out_o(ip), .torque_limit_active_out_o(tq),
      .fault_flag_out_o(flt), .brake_control_out_o(bc), .overload_level_out_o(ol),
      .caution_out_o(cau), .velocity_match_out_o(vm), .do_o(dout), .irq_o(irq));
   sso_plc_model u_plc (.clk_i(clk_i), .do_i(dout), .seen_o(seen));
   task test_done;
      if (fails == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One bus access; request held until waitrequest is sampled low at a rising edge
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      bit got;
      got = 0;
      @(posedge clk_i);
      adr <= a[7:2]; rd <= !w; wr <= w; wd <= d;
      for (int k = 0; k < 50 && !got; k++) begin
         @(posedge clk_i);
         if (wq === 1'b0) begin
            got = 1;
            rdat = rdo;
         end
      end
      if (!got) begin
         fails++;
         test_done();
      end
      rd <= 0; wr <= 0;
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(0, a, 32'h0);
      chk("register", e, rdat);
   endtask
   // Let pin synchronisers and output flops settle before looking
   task settle;
      repeat (5) @(negedge clk_i);
      @(posedge clk_i);
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      for (i = 0; i < 8; i++) rdchk(ra[i], rv[i]);
      pg <= 1; servo_enable_out <= 1; sok <= 1; brk <= 1; tl <= 1;
      settle();
      chk("ready", 1, rdy);
      chk("servo", 1, sen);
      chk("brake", 1, bc);
      chk("ready terminal", 1, seen[0]);
      sok <= 0; ca <= 1;
      settle();
      chk("ready alarm", 0, rdy);
      chk("brake off", 0, bc);
      chk("fault", 1, flt);
      chk("fault terminal", 1, seen[4]);
      ca <= 0; sok <= 1;
      // Caution causes alone must not raise the fault flag
      for (i = 0; i < 5; i++) begin
         cv <= 5'h01 << i;
         settle();
         chk("caution", 1, cau);
         chk("fault excluded", 0, flt);
      end
      cv <= 5'h00;
      for (i = 0; i < 6; i++) begin
         fb <= sp[i];
         settle();
         chk("near zero", ex[i][1], nz);
         chk("above", ex[i][0], ab);
      end
      bus(1, 8'h04, 32'h0BB9);
      fb <= 16'sd3000;
      settle();
      chk("near zero new limit", 1, nz);
      fb <= 16'sd3500; cmd <= 16'sd3509; pe <= 32'sd99;
      // Every mode: qualified flags and the mode-dependent default terminals
      for (i = 0; i < 8; i++) begin
         bus(1, 8'h00, i);
         settle();
         chk("in position", i == 0 || i == 5 || i == 6, ip);
         chk("speed match", i == 1 || i == 3, vm);
         chk("torque limit", !(i == 2 || i == 4), tq);
         chk("do3", !(i == 0 || i == 5 || i == 6), seen[2]);
         chk("do4", i == 0 || i == 5 || i == 6, seen[3]);
      end
      bus(1, 8'h00, 32'h0);
      pe <= -32'sd100; cmd <= 16'sd3490;
      settle();
      chk("window edge", 0, ip);
      ovl <= 1;
      settle();
      chk("overload", 1, ol);
      chk("do6 unassigned", 0, seen[5]);
      bus(1, 8'h14, 32'h00900000);
      settle();
      chk("do6 assigned", 1, seen[5]);
      ovl <= 0;
      // Sticky status, mask and write-one-to-clear
      bus(1, 8'h1C, 32'h7);
      rdchk(8'h1C, 32'h0);
      bus(1, 8'h20, 32'h1);
      cv <= 5'h04;
      settle();
      chk("masked irq", 0, irq);
      rdchk(8'h1C, 32'h2);
      oa <= 1;
      settle();
      chk("irq", 1, irq);
      bus(1, 8'h1C, 32'h3);
      rdchk(8'h1C, 32'h0);
      chk("irq cleared", 0, irq);
      test_done();
   end
   initial begin
      #900000;
      fails++;
      test_done();
   end
endmodule
